// [dac_regs.svh]
// constants for the dual converter two-wire command slave
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH

`define DAC_CODE_W      10
`define DAC_CODE_RESET  10'h000
`define ADDR_HI_VAR_L   6'h1c
`define ADDR_HI_VAR_M   6'h2c
`define ADDR_BITS_LAST  4'h7
`define BYTE_BITS       4'h8
`define BIT_CNT_ZERO    4'h0
`define BIT_CNT_ONE     4'h1
`define ADDR_TOP_IDX    3'h6

`define CMD_LOAD_A      4'h0
`define CMD_LOAD_B      4'h1
`define CMD_IN_A        4'h4
`define CMD_IN_B        4'h5
`define CMD_XFER_IN_A   4'h8
`define CMD_XFER_IN_B   4'h9
`define CMD_LOAD_ALL    4'hc
`define CMD_IN_ALL      4'hd
`define CMD_UPDATE      4'he
`define CMD_SPECIAL     4'hf

`define SUB_EXTENDED    4'h0
`define SUB_READ_A      4'h1
`define SUB_READ_B      4'h2

`define PD_SEL_A_BIT    3
`define PD_SEL_B_BIT    2
`define PD_MODE_HI_BIT  1
`define PD_MODE_LO_BIT  0
`define PD_MODE_ON      2'h0
`define PD_MODE_FLOAT   2'h1
`define PD_MODE_1K      2'h2
`define PD_MODE_100K    2'h3

`define READ_PAD_HI     4'h0
`define READ_PAD_LO     2'h0

`endif

// [dac_pkg.sv]
// types shared by the converter command slave
`include "dac_regs.svh"
`default_nettype none
package dac_pkg;

	typedef enum logic [2:0] {
		S_IDLE      = 3'h0,
		S_ADDR      = 3'h1,
		S_ADDR_ACK  = 3'h3,
		S_WRITE     = 3'h2,
		S_WRITE_ACK = 3'h6,
		S_READ      = 3'h7,
		S_READ_ACK  = 3'h5,
		S_SPARE     = 3'h4
	} state_t;

	typedef struct packed {
		state_t                   state;
		logic                     scl_d;
		logic                     sda_d;
		logic [3:0]               bit_cnt;
		logic [7:0]               shift;
		logic [7:0]               hold;
		logic                     byte_idx;
		logic                     rw;
		logic                     ext_pending;
		logic                     rd_sel;
		logic                     ack_ok;
		logic                     tx_second;
		logic                     sda_out;
		logic                     sda_oe;
		logic                     scl_conn;
		logic [`DAC_CODE_W-1:0]   in_a;
		logic [`DAC_CODE_W-1:0]   in_b;
		logic [`DAC_CODE_W-1:0]   out_a;
		logic [`DAC_CODE_W-1:0]   out_b;
		logic [1:0]               pd_a;
		logic [1:0]               pd_b;
	} slave_state_t;

endpackage
`default_nettype wire

// [pin_sync.sv]
// two-flop synchroniser for pins from outside the clock domain
`default_nettype none
module pin_sync #(
	parameter int         W         = 1,
	parameter logic [W-1:0] RESET_VAL = '1
) (
	input  wire logic         sys_clk_i, // system clock
	input  wire logic         reset_i,   // synchronous reset, high
	input  wire logic [W-1:0] async_i,   // raw pin levels
	output var  logic [W-1:0] sync_o     // synchronised levels
);
	logic [W-1:0] meta_reg;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge sys_clk_i) begin
				if (reset_i) begin
					meta_reg[g] <= RESET_VAL[g];
					sync_o[g]   <= RESET_VAL[g];
				end else begin
					meta_reg[g] <= async_i[g];
					sync_o[g]   <= meta_reg[g];
				end
			end
		end
	endgenerate
endmodule // pin_sync
`default_nettype wire

// [dac_serial_slave.sv]
// two-wire command slave for a dual 10-bit converter
// Functional notes
// - idle waits for START then address, compares bit by bit, drops on mismatch.
// - last address bit is direction: 0 master writes, 1 device sends.
// - own address is acknowledged by pulling data low one clock.
// - upper six address bits fixed per variant, lowest follows select pin.
// - variant bases 0111 00x and 1011 00x give four addresses.
// - writes commit on the clock fall ending the acknowledge bit.
// - a write cut short changes nothing; master repeats it whole.
// - command all ones with zero top code enters extended power-down word.
// - each set channel select takes the given power-down mode.
// - mode 00 on, 01 float, 10 1k to ground, 11 100k.
// - power-up clears output codes, both channels 100k power-down.
// - read sends first byte, waits master acknowledge, sends second.
// - no general call response, seven-bit addressing only.
// - after mismatch the clock is gated off until next START.
// - 0000/0001 load channel input and output, copy other, update all.
// - 0100/0101 load one input register, outputs unchanged.
// - 1000/1001 move all inputs to outputs, then load one input.
// - 1100 loads both inputs and outputs, 1101 both inputs only.
// - 1110 updates all outputs from inputs, no data byte follows.
// - 1111 with 0001/0010 selects read of A or B before repeated START.
`include "dac_regs.svh"
`default_nettype none
module dac_serial_slave #(
	parameter logic [5:0] ADDR_HI = `ADDR_HI_VAR_L // fixed upper address bits
) (
	input  wire logic                   sys_clk_i,           // 25 MHz clock
	input  wire logic                   reset_i,             // synchronous reset, high
	input  wire logic                   scl_i,               // serial clock pin
	input  wire logic                   sda_i,               // serial data pin level
	output var  logic                   sda_o,               // data drive value, low
	output var  logic                   sda_oe_o,            // high while pulling data low
	input  wire logic                   addr_sel_i,          // address select pin
	output var  logic [`DAC_CODE_W-1:0] channel_a_output_o,  // channel A output code
	output var  logic [`DAC_CODE_W-1:0] channel_b_output_o,  // channel B output code
	output var  logic [1:0]             pd_mode_a_o,         // channel A power-down mode
	output var  logic [1:0]             pd_mode_b_o,         // channel B power-down mode
	output var  logic                   scl_connected_o      // clock reaches the core
);
	dac_pkg::slave_state_t st_reg;
	dac_pkg::slave_state_t st_next;
	logic [2:0]            sync_w;
	logic                  scl_s;
	logic                  sda_s;
	logic                  sel_s;
	logic                  rise;
	logic                  fall;
	logic                  start_c;
	logic                  stop_c;
	logic [6:0]            own_addr;
	logic [3:0]            cmd;
	logic [3:0]            code_top;
	logic [`DAC_CODE_W-1:0] code;
	logic [15:0]           rd_word;
	logic                  commit_b1;
	logic                  commit_b2;

	pin_sync #(
		.W         (3),
		.RESET_VAL (3'h7)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.async_i   ({scl_i, sda_i, addr_sel_i}),
		.sync_o    (sync_w)
	);

	assign scl_s    = sync_w[2];
	assign sda_s    = sync_w[1];
	assign sel_s    = sync_w[0];
	assign rise     = scl_s & ~st_reg.scl_d;
	assign fall     = ~scl_s & st_reg.scl_d;
	assign start_c  = scl_s & st_reg.scl_d & st_reg.sda_d & ~sda_s;
	assign stop_c   = scl_s & st_reg.scl_d & ~st_reg.sda_d & sda_s;
	assign own_addr = {ADDR_HI, sel_s};
	assign cmd      = st_reg.hold[7:4];
	assign code_top = st_reg.hold[3:0];
	assign code     = {st_reg.hold[3:0], st_reg.shift[7:2]};     // sub-bits dropped
	// read word mirrors write layout: zero nibble, code, zero sub-bits
	assign rd_word  = {`READ_PAD_HI, (st_reg.rd_sel ? st_reg.out_b : st_reg.out_a),
		`READ_PAD_LO};
	assign commit_b1 = fall && (st_reg.state == dac_pkg::S_WRITE_ACK) && !st_reg.byte_idx;
	assign commit_b2 = fall && (st_reg.state == dac_pkg::S_WRITE_ACK) && st_reg.byte_idx;

	always_comb begin
		st_next       = st_reg;
		st_next.scl_d = scl_s;
		st_next.sda_d = sda_s;
		st_next.sda_out = 1'b0;
		if (start_c) begin
			// also a repeated START; any partial word is abandoned here
			st_next.state    = dac_pkg::S_ADDR;
			st_next.bit_cnt  = `BIT_CNT_ZERO;
			st_next.byte_idx = 1'b0;
			st_next.sda_oe   = 1'b0;
			st_next.scl_conn = 1'b1;
		end else if (stop_c) begin
			st_next.state    = dac_pkg::S_IDLE;
			st_next.byte_idx = 1'b0;
			st_next.sda_oe   = 1'b0;
			st_next.scl_conn = 1'b0;
		end else begin
			case (st_reg.state)
				dac_pkg::S_ADDR: begin
					if (rise) begin
						st_next.shift   = {st_reg.shift[6:0], sda_s};
						st_next.bit_cnt = st_reg.bit_cnt + `BIT_CNT_ONE;
						if (st_reg.bit_cnt == `ADDR_BITS_LAST) begin
							st_next.rw = sda_s;
						end else if (sda_s !=
							own_addr[`ADDR_TOP_IDX - st_reg.bit_cnt[2:0]]) begin
							// fixed bits are nonzero, so a general call never matches
							st_next.state    = dac_pkg::S_IDLE;
							st_next.scl_conn = 1'b0;
						end
					end else if (fall && st_reg.bit_cnt == `BYTE_BITS) begin
						st_next.state   = dac_pkg::S_ADDR_ACK;
						st_next.sda_oe  = 1'b1;
						st_next.bit_cnt = `BIT_CNT_ZERO;
					end
				end
				dac_pkg::S_ADDR_ACK: begin
					if (fall) begin
						st_next.bit_cnt = `BIT_CNT_ZERO;
						if (st_reg.rw) begin
							st_next.state     = dac_pkg::S_READ;
							st_next.shift     = rd_word[15:8];
							st_next.sda_oe    = ~rd_word[15];
							st_next.tx_second = 1'b0;
						end else begin
							st_next.state  = dac_pkg::S_WRITE;
							st_next.sda_oe = 1'b0;
						end
					end
				end
				dac_pkg::S_WRITE: begin
					if (rise) begin
						st_next.shift   = {st_reg.shift[6:0], sda_s};
						st_next.bit_cnt = st_reg.bit_cnt + `BIT_CNT_ONE;
					end else if (fall && st_reg.bit_cnt == `BYTE_BITS) begin
						st_next.state   = dac_pkg::S_WRITE_ACK;
						st_next.sda_oe  = 1'b1;
						st_next.bit_cnt = `BIT_CNT_ZERO;
					end
				end
				dac_pkg::S_WRITE_ACK: begin
					if (fall) begin
						st_next.state  = dac_pkg::S_WRITE;
						st_next.sda_oe = 1'b0;
						if (!st_reg.byte_idx) begin
							st_next.hold     = st_reg.shift;
							st_next.byte_idx = 1'b1;
							if (!st_reg.ext_pending && st_reg.shift[7:4] == `CMD_UPDATE) begin
								st_next.out_a    = st_reg.in_a;
								st_next.out_b    = st_reg.in_b;
								st_next.byte_idx = 1'b0;
							end else if (!st_reg.ext_pending &&
								st_reg.shift[7:4] == `CMD_SPECIAL) begin
								if (st_reg.shift[3:0] == `SUB_READ_A)
									st_next.rd_sel = 1'b0;
								else if (st_reg.shift[3:0] == `SUB_READ_B)
									st_next.rd_sel = 1'b1;
							end
						end else begin
							st_next.byte_idx = 1'b0;
							if (st_reg.ext_pending) begin
								st_next.ext_pending = 1'b0;
								// mode bits stored exactly as sent, the raw two-bit field
								if (st_reg.shift[`PD_SEL_A_BIT])
									st_next.pd_a = {st_reg.shift[`PD_MODE_HI_BIT],
										st_reg.shift[`PD_MODE_LO_BIT]};
								if (st_reg.shift[`PD_SEL_B_BIT])
									st_next.pd_b = {st_reg.shift[`PD_MODE_HI_BIT],
										st_reg.shift[`PD_MODE_LO_BIT]};
							end else begin
								case (cmd)
									`CMD_LOAD_A: begin
										st_next.in_a  = code;
										st_next.out_a = code;
										st_next.out_b = st_reg.in_b;
									end
									`CMD_LOAD_B: begin
										st_next.in_b  = code;
										st_next.out_b = code;
										st_next.out_a = st_reg.in_a;
									end
									`CMD_IN_A: st_next.in_a = code;
									`CMD_IN_B: st_next.in_b = code;
									`CMD_XFER_IN_A: begin
										st_next.out_a = st_reg.in_a;
										st_next.out_b = st_reg.in_b;
										st_next.in_a  = code;
									end
									`CMD_XFER_IN_B: begin
										st_next.out_a = st_reg.in_a;
										st_next.out_b = st_reg.in_b;
										st_next.in_b  = code;
									end
									`CMD_LOAD_ALL: begin
										st_next.in_a  = code;
										st_next.in_b  = code;
										st_next.out_a = code;
										st_next.out_b = code;
									end
									`CMD_IN_ALL: begin
										st_next.in_a = code;
										st_next.in_b = code;
									end
									`CMD_SPECIAL: begin
										if (code_top == `SUB_EXTENDED)
											st_next.ext_pending = 1'b1;
									end
									default: begin
									end
								endcase
							end
						end
					end
				end
				dac_pkg::S_READ: begin
					if (fall) begin
						st_next.bit_cnt = st_reg.bit_cnt + `BIT_CNT_ONE;
						if (st_reg.bit_cnt == `ADDR_BITS_LAST) begin
							st_next.state  = dac_pkg::S_READ_ACK;
							st_next.sda_oe = 1'b0;
						end else begin
							st_next.shift  = {st_reg.shift[6:0], 1'b0};
							st_next.sda_oe = ~st_reg.shift[6];
						end
					end
				end
				dac_pkg::S_READ_ACK: begin
					if (rise) begin
						st_next.ack_ok = ~sda_s;
					end else if (fall) begin
						st_next.bit_cnt = `BIT_CNT_ZERO;
						if (st_reg.ack_ok && !st_reg.tx_second) begin
							st_next.state     = dac_pkg::S_READ;
							st_next.shift     = rd_word[7:0];
							st_next.sda_oe    = ~rd_word[7];
							st_next.tx_second = 1'b1;
						end else begin
							// done or refused: rest until the next START
							st_next.state    = dac_pkg::S_IDLE;
							st_next.scl_conn = 1'b0;
						end
					end
				end
				default: begin
					st_next.state = dac_pkg::S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_reg           <= '0;
			st_reg.state     <= dac_pkg::S_IDLE;
			st_reg.scl_d     <= 1'b1;
			st_reg.sda_d     <= 1'b1;
			st_reg.out_a     <= `DAC_CODE_RESET;
			st_reg.out_b     <= `DAC_CODE_RESET;
			st_reg.pd_a      <= `PD_MODE_100K;
			st_reg.pd_b      <= `PD_MODE_100K;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sda_o              = st_reg.sda_out;
	assign sda_oe_o           = st_reg.sda_oe;
	assign channel_a_output_o = st_reg.out_a;
	assign channel_b_output_o = st_reg.out_b;
	assign pd_mode_a_o        = st_reg.pd_a;
	assign pd_mode_b_o        = st_reg.pd_b;
	assign scl_connected_o    = st_reg.scl_conn;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	AST_RESET_STATE: assert property (disable iff (1'b0) $past(reset_i) && !reset_i |->
		channel_a_output_o == `DAC_CODE_RESET && pd_mode_b_o == `PD_MODE_100K)
		else $error("reset values wrong");
	AST_ADDR_MATCH: assert property ($rose(st_reg.state == dac_pkg::S_ADDR_ACK) |->
		$past(st_reg.shift[7:1]) == own_addr && sda_oe_o)
		else $error("acknowledged a foreign address");
	AST_ACK_HOLD: assert property (st_reg.state == dac_pkg::S_ADDR_ACK |-> sda_oe_o)
		else $error("address ack not driven");
	AST_MISMATCH_GATE: assert property ($past(st_reg.state) == dac_pkg::S_ADDR &&
		st_reg.state == dac_pkg::S_IDLE |-> !scl_connected_o)
		else $error("clock not gated after mismatch");
	AST_COMMIT_EDGE: assert property ($changed(channel_a_output_o) |->
		$past(fall && st_reg.state == dac_pkg::S_WRITE_ACK))
		else $error("output changed outside ack fall");
	AST_ABORT_KEEPS: assert property (st_reg.state == dac_pkg::S_WRITE && (start_c || stop_c)
		|=> $stable(st_reg.in_a) && $stable(channel_b_output_o) [*2])
		else $error("aborted write changed a register");
	AST_LOAD_A: assert property (commit_b2 && !st_reg.ext_pending && cmd == `CMD_LOAD_A |=>
		channel_a_output_o == $past(code) && channel_b_output_o == $past(st_reg.in_b))
		else $error("load A wrong");
	AST_INPUT_ONLY: assert property (commit_b2 && !st_reg.ext_pending &&
		(cmd == `CMD_IN_A || cmd == `CMD_IN_B) |=> $stable(channel_a_output_o) &&
		$stable(channel_b_output_o))
		else $error("input-only command moved an output");
	AST_XFER: assert property (commit_b2 && !st_reg.ext_pending && cmd == `CMD_XFER_IN_A |=>
		channel_a_output_o == $past(st_reg.in_a) && st_reg.in_a == $past(code))
		else $error("transfer then load wrong");
	AST_PD_APPLY: assert property (commit_b2 && st_reg.ext_pending &&
		st_reg.shift[`PD_SEL_A_BIT] |=> pd_mode_a_o == $past(st_reg.shift[1:0]))
		else $error("power-down mode not applied");

	COV_WRITE: cover property (commit_b2 && cmd == `CMD_LOAD_ALL);
	COV_READ_2ND: cover property (st_reg.state == dac_pkg::S_READ && st_reg.tx_second);
	COV_PD: cover property (commit_b2 && st_reg.ext_pending);
	COV_MISMATCH: cover property ($fell(scl_connected_o) && st_reg.state == dac_pkg::S_IDLE);
endmodule // dac_serial_slave
`default_nettype wire

// [bus_master_model.sv]
// two-wire bus master model that paces the clock and pulls the data wire
`default_nettype none
module bus_master_model (
	input  wire logic sys_clk_i,  // system clock, paces the bus
	input  wire logic sda_i,      // resolved data wire
	output var  logic scl_o,      // serial clock, high between frames
	output var  logic sda_pull_o  // high while pulling data low
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// doubles as repeated start; the long low phase lets the slave release first
	task automatic bus_start();
		sda_pull_o <= 1'b0;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
		sda_pull_o <= 1'b1;
		tick(4);
		scl_o <= 1'b0;
		tick(2);
	endtask

	task automatic bus_stop();
		sda_pull_o <= 1'b1;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_pull_o <= 1'b0;
		tick(8);
	endtask

	// one 8-cycle bit: data set mid low phase, wire sampled late in high phase
	task automatic clock_bit(input logic b, output logic s);
		sda_pull_o <= ~b;
		tick(2);
		scl_o <= 1'b1;
		tick(3);
		s = sda_i;
		tick(1);
		scl_o <= 1'b0;
		tick(2);
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(d[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	endtask

	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clock_bit(1'b1, d[i]);
		clock_bit(~ack, s);
	endtask
endmodule // bus_master_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the converter two-wire command slave
`include "dac_regs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 40000; // about four times the expected run

	logic        sys_clk_i;
	logic        reset_i;
	logic        addr_sel_i;
	logic        scl;
	logic        sda_pull;
	wire         sda_wire;
	logic        sda_o;
	logic        sda_oe;
	logic        conn;
	logic [9:0]  out_a;
	logic [9:0]  out_b;
	logic [1:0]  pd_a;
	logic [1:0]  pd_b;
	logic [6:0]  own;
	logic [9:0]  exp_in_a;
	logic [9:0]  exp_in_b;
	logic [9:0]  exp_out_a;
	logic [9:0]  exp_out_b;
	logic [1:0]  exp_pd_a;
	logic [1:0]  exp_pd_b;
	logic        ext;
	int          n_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	// {command, code, sub bits}; unlisted commands sit near the end
	logic [15:0] cmd_tab [18] = '{16'h4554, 16'h1aa8, 16'h5ffc, 16'h0004, 16'hcffc, 16'hd3c0,
		16'h8800, 16'h9f0c, 16'hea00, 16'h42a8, 16'h2444, 16'h3444, 16'h6444, 16'h7444,
		16'ha444, 16'hb444, 16'hf300, 16'he500};
	logic [7:0]  pd_tab [6] = '{8'h0c, 8'h09, 8'h06, 8'h0b, 8'h04, 8'h03};
	logic [6:0]  bad_tab [5] = '{7'h00, 7'h78, 7'h58, 7'h39, 7'h18};

	assign own = {`ADDR_HI_VAR_L, addr_sel_i};
	// open-drain wire with pull-up
	assign sda_wire = ~(sda_pull | (sda_oe & ~sda_o));

	dac_serial_slave #(.ADDR_HI(`ADDR_HI_VAR_L)) i_dac_serial_slave (
		.sys_clk_i          (sys_clk_i),
		.reset_i            (reset_i),
		.scl_i              (scl),
		.sda_i              (sda_wire),
		.sda_o              (sda_o),
		.sda_oe_o           (sda_oe),
		.addr_sel_i         (addr_sel_i),
		.channel_a_output_o (out_a),
		.channel_b_output_o (out_b),
		.pd_mode_a_o        (pd_a),
		.pd_mode_b_o        (pd_b),
		.scl_connected_o    (conn)
	);

	bus_master_model i_bus_master_model (
		.sys_clk_i  (sys_clk_i),
		.sda_i      (sda_wire),
		.scl_o      (scl),
		.sda_pull_o (sda_pull)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	task automatic conclude();
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_errors++;
			conclude();
		end
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic check_outs();
		check("channel a output", 16'(exp_out_a), 16'(out_a));
		check("channel b output", 16'(exp_out_b), 16'(out_b));
		check("channel a power mode", 16'(exp_pd_a), 16'(pd_a));
		check("channel b power mode", 16'(exp_pd_b), 16'(pd_b));
	endtask

	task automatic apply(input logic [7:0] b1, input logic [7:0] b2);
		logic [9:0] d;
		d = {b1[3:0], b2[7:2]};
		if (ext) begin
			ext = 1'b0;
			if (b2[`PD_SEL_A_BIT])
				exp_pd_a = b2[1:0];
			if (b2[`PD_SEL_B_BIT])
				exp_pd_b = b2[1:0];
		end else begin
			case (b1[7:4])
				`CMD_LOAD_A: {exp_in_a, exp_out_a, exp_out_b} = {d, d, exp_in_b};
				`CMD_LOAD_B: {exp_in_b, exp_out_b, exp_out_a} = {d, d, exp_in_a};
				`CMD_IN_A: exp_in_a = d;
				`CMD_IN_B: exp_in_b = d;
				`CMD_XFER_IN_A, `CMD_XFER_IN_B: begin
					{exp_out_a, exp_out_b} = {exp_in_a, exp_in_b};
					if (b1[4])
						exp_in_b = d;
					else
						exp_in_a = d;
				end
				`CMD_LOAD_ALL: {exp_in_a, exp_in_b, exp_out_a, exp_out_b} = {4{d}};
				`CMD_IN_ALL: {exp_in_a, exp_in_b} = {2{d}};
				`CMD_UPDATE: {exp_out_a, exp_out_b} = {exp_in_a, exp_in_b};
				`CMD_SPECIAL: ext = (d[9:6] == `SUB_EXTENDED);
				default: ;
			endcase
		end
	endtask

	task automatic addr_phase(input logic [6:0] a, input logic rw, input logic hit);
		logic ack;
		i_bus_master_model.bus_start();
		i_bus_master_model.send_byte({a, rw}, ack);
		check("address ack", 16'(hit), 16'(ack));
		check("clock connected", 16'(hit), 16'(conn));
		check("data drive value", 16'h0000, 16'(sda_o));
	endtask

	// hold keeps the bus for a repeated start instead of a stop
	task automatic write_word(input logic [7:0] b1, input logic [7:0] b2, input int n,
			input logic hold);
		logic ack;
		addr_phase(own, 1'b0, 1'b1);
		i_bus_master_model.send_byte(b1, ack);
		check("command byte ack", 16'(1'b1), 16'(ack));
		if (n > 1) begin
			check_outs();
			i_bus_master_model.send_byte(b2, ack);
			check("data byte ack", 16'(1'b1), 16'(ack));
		end
		if (!hold)
			i_bus_master_model.bus_stop();
		if (n > 1 || (!ext && b1[7:5] == 3'h7))
			apply(b1, b2);
		check_outs();
	endtask

	task automatic read_chan(input logic b);
		logic [7:0] d1;
		logic [7:0] d2;
		write_word({`CMD_SPECIAL, b ? `SUB_READ_B : `SUB_READ_A}, 8'h00, 1, 1'b1);
		addr_phase(own, 1'b1, 1'b1);
		i_bus_master_model.recv_byte(1'b1, d1);
		i_bus_master_model.recv_byte(1'b0, d2);
		i_bus_master_model.bus_stop();
		check("read word", {4'h0, b ? exp_out_b : exp_out_a, 2'h0}, {d1, d2});
	endtask

	initial begin
		reset_i = 1'b1;
		addr_sel_i = 1'b0;
		{exp_in_a, exp_in_b, exp_out_a, exp_out_b} = '0;
		exp_pd_a = `PD_MODE_100K;
		exp_pd_b = `PD_MODE_100K;
		ext = 1'b0;
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		check_outs();
		check("data drive after reset", 16'h0000, 16'(sda_oe));
		foreach (bad_tab[i]) begin
			addr_phase(bad_tab[i], 1'b0, 1'b0);
			i_bus_master_model.bus_stop();
		end
		foreach (cmd_tab[i]) begin
			write_word(cmd_tab[i][15:8], cmd_tab[i][7:0],
				(cmd_tab[i][15:12] == `CMD_UPDATE) ? 1 : 2, 1'b0);
		end
		read_chan(1'b0);
		read_chan(1'b1);
		write_word(8'h03, 8'hfc, 1, 1'b0);
		write_word(8'h03, 8'hfc, 2, 1'b0);
		foreach (pd_tab[i]) begin
			write_word(8'hf0, 8'h00, 2, 1'b0);
			write_word(8'h00, pd_tab[i], 2, 1'b0);
		end
		addr_sel_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		addr_phase({`ADDR_HI_VAR_L, 1'b0}, 1'b0, 1'b0);
		i_bus_master_model.bus_stop();
		write_word(8'h13, 8'h08, 2, 1'b0);
		read_chan(1'b1);
		conclude();
	end
endmodule // testbench
`default_nettype wire
